// file: hw/rlb_pkg.sv
// Package: register map, field layout and carrier types for the relay bank
package rlb_pkg;

  localparam int unsigned PORT_COUNT = 4;
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 2;
  localparam int unsigned RELAY_COUNT = PORT_COUNT * PORT_WIDTH;

  // Byte offsets from the I/O base
  localparam logic [ADDR_WIDTH-1:0] RELAY_BANK_ONE_DRIVE_OFS = 2'h0;
  localparam logic [ADDR_WIDTH-1:0] RELAY_BANK_TWO_DRIVE_OFS = 2'h1;
  localparam logic [ADDR_WIDTH-1:0] RELAY_BANK_THREE_DRIVE_OFS = 2'h2;
  localparam logic [ADDR_WIDTH-1:0] RELAY_BANK_FOUR_DRIVE_OFS = 2'h3;

  // Reset value of every drive register: all relays open
  localparam logic [PORT_WIDTH-1:0] DRIVE_RESET = 8'h00;
  localparam logic [PORT_WIDTH-1:0] READ_IDLE = 8'h00;

  typedef logic [PORT_WIDTH-1:0] rlb_byte_t;
  typedef logic [ADDR_WIDTH-1:0] rlb_addr_t;

  // Host access request
  typedef struct packed {
    logic write;
    logic read;
    rlb_addr_t addr;
    rlb_byte_t data;
  } rlb_req_s;

  // Read answer
  typedef struct packed {
    logic valid;
    rlb_byte_t data;
  } rlb_rsp_s;

endpackage : rlb_pkg

// file: hw/rlb_drive_store.sv
// Four byte-wide relay drive registers with registered read-back
`timescale 1ns/1ns

module rlb_drive_store
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_write,
  input wire logic i_read,
  input wire rlb_pkg::rlb_addr_t i_addr,
  input wire rlb_pkg::rlb_byte_t i_data,
  output logic [rlb_pkg::RELAY_COUNT-1:0] o_drive,
  output rlb_pkg::rlb_byte_t o_read_data
);

  rlb_pkg::rlb_byte_t store_reg [rlb_pkg::PORT_COUNT];
  rlb_pkg::rlb_byte_t read_reg;
  rlb_pkg::rlb_byte_t read_next;

  // Ones complement of the live drive value
  assign read_next = i_read ? ~store_reg[i_addr] : rlb_pkg::READ_IDLE; // R4

  genvar g;
  generate
    for (g = 0; g < rlb_pkg::PORT_COUNT; g++)
    begin : g_port
      wire logic hit;
      assign hit = i_write && (i_addr == rlb_pkg::rlb_addr_t'(g)); // R2
      always_ff @(posedge i_clock)
      begin
        if (i_reset)
          store_reg[g] <= rlb_pkg::DRIVE_RESET; // R8
        else if (hit)
          store_reg[g] <= i_data; // R5
      end
      // Bit b of port g drives relay 8g+b+1
      assign o_drive[g*rlb_pkg::PORT_WIDTH +: rlb_pkg::PORT_WIDTH] =
        store_reg[g]; // R2
    end
  endgenerate

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      read_reg <= rlb_pkg::READ_IDLE;
    else
      read_reg <= read_next;
  end

  assign o_read_data = read_reg;

endmodule : rlb_drive_store

// file: hw/rlb_relay_bank.sv
// Top of the relay output port bank: host port and relay coil drive
`timescale 1ns/1ns

// Behaviour
// R1: Four eight-bit relay output ports sit at small offsets from base.
// R2: Port n decodes at base plus n; bit b drives relay 8n+b+1.
// R3: Port numbers count from zero, one per consecutive offset.
// R4: Reading a port returns the inverse of its current drive value.
// R5: Writing one to a bit closes that relay.
// R6: A relay with a zero drive bit stays open.
// R7: No input ports; every address is a writable, readable output.
// R8: Reset clears all drive registers, so reads then return all ones.
module rlb_relay_bank
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire rlb_pkg::rlb_req_s i_req,
  output rlb_pkg::rlb_rsp_s o_rsp,
  output logic [rlb_pkg::RELAY_COUNT-1:0] o_relay_close
);

  // ==========================================================
  // Decode helpers

  // True when the offset selects port idx
  function automatic logic rlb_port_match
  (
    input rlb_pkg::rlb_addr_t addr,
    input int unsigned idx
  );
    return addr == rlb_pkg::rlb_addr_t'(idx);
  endfunction : rlb_port_match

  // A read counts only when no write shares its cycle
  function automatic logic rlb_read_only
  (
    input logic rd,
    input logic wr
  );
    return rd && !wr;
  endfunction : rlb_read_only

  // Linear relay bit index of bit b in port idx
  function automatic int unsigned rlb_relay_index
  (
    input int unsigned idx,
    input int unsigned b
  );
    return idx * rlb_pkg::PORT_WIDTH + b;
  endfunction : rlb_relay_index

  // ==========================================================
  // Request signals

  wire logic req_write;
  wire logic req_read;
  wire rlb_pkg::rlb_addr_t req_addr;
  wire rlb_pkg::rlb_byte_t req_data;

  wire logic wr_take;
  wire logic rd_take;

  wire logic [rlb_pkg::PORT_COUNT-1:0] wr_sel;
  wire logic [rlb_pkg::PORT_COUNT-1:0] rd_sel;
  wire logic rd_hit;

  // ==========================================================
  // Store and coil signals

  // Relay-wide drive and coil vectors
  wire logic [rlb_pkg::RELAY_COUNT-1:0] drive;
  wire logic [rlb_pkg::RELAY_COUNT-1:0] close_vec;
  rlb_pkg::rlb_byte_t read_data;

  // ==========================================================
  // Response signals

  // Registered answer to the host
  wire rlb_pkg::rlb_rsp_s rsp_vec;
  logic valid_reg;
  logic valid_next;

  // ==========================================================
  // Request fields

  // Named views of the request struct
  assign req_write = i_req.write;
  assign req_read = i_req.read;
  assign req_addr = i_req.addr;
  assign req_data = i_req.data;

  // ==========================================================
  // Request decode

  // Write wins over a read in the same cycle
  assign wr_take = req_write; // R7
  assign rd_take = rlb_read_only(req_read, req_write); // R7

  // ==========================================================
  // Port select

  // One-hot selects for write and read
  genvar p;
  generate

    for (p = 0; p < rlb_pkg::PORT_COUNT; p++)
    begin : g_sel

      assign wr_sel[p] = wr_take && rlb_port_match(req_addr, p); // R2 R3
      assign rd_sel[p] = rd_take && rlb_port_match(req_addr, p); // R2 R3

    end

  endgenerate

  // Every offset selects an implemented output port
  assign rd_hit = |rd_sel; // R7

  // ==========================================================
  // Drive store

  // Registers live here; read data leave them inverted
  rlb_drive_store u_store
  (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_write(wr_take),
    .i_read(rd_take),
    .i_addr(req_addr), // R3
    .i_data(req_data),
    .o_drive(drive),
    .o_read_data(read_data)
  );

  // ==========================================================
  // Coil hold registers
  // Coils reload only after a write to their own port

  genvar q;
  genvar b;
  generate

    for (q = 0; q < rlb_pkg::PORT_COUNT; q++)
    begin : g_coil

      rlb_pkg::rlb_byte_t lane;
      logic load_reg;
      logic load_next;

      assign lane = drive[rlb_relay_index(q, 0) +: rlb_pkg::PORT_WIDTH];
      assign load_next = wr_sel[q];

      // Pulse marks the cycle after a write to this port
      always_ff @(posedge i_clock)
      begin
        if (i_reset)
        begin
          load_reg <= 1'b0;
        end
        else
        begin
          load_reg <= load_next;
        end
      end

      for (b = 0; b < rlb_pkg::PORT_WIDTH; b++)
      begin : g_bit

        localparam int unsigned RELAY_IDX = rlb_relay_index(q, b);
        logic hold_reg;
        logic hold_next;

        // Relay 8q+b+1 follows drive bit b of port q
        assign hold_next = load_reg ? lane[b] : hold_reg; // R2 R5

        // Reset leaves every coil open
        always_ff @(posedge i_clock)
        begin
          if (i_reset)
          begin
            hold_reg <= rlb_pkg::DRIVE_RESET[b]; // R6 R8
          end
          else
          begin
            hold_reg <= hold_next;
          end
        end

        assign close_vec[RELAY_IDX] = hold_reg; // R6
      end
    end

  endgenerate

  // ==========================================================
  // Read response

  // One-cycle valid after each accepted read
  assign valid_next = rd_hit; // R4

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      valid_reg <= 1'b0; // R8
    end
    else
    begin
      valid_reg <= valid_next;
    end
  end

  // ==========================================================
  // Outputs

  // Read data stay zero between reads
  assign rsp_vec = '{valid: valid_reg, data: read_data}; // R4
  assign o_rsp = rsp_vec;

  // Bit k closes relay k+1
  assign o_relay_close = close_vec; // R1 R6

endmodule : rlb_relay_bank

// file: tb/rlb_relay_coils.sv
// Relay contacts
`timescale 1ns/1ns
module rlb_relay_coils
(
  input wire logic [31:0] i_coil,
  output logic [31:0] o_contact
);
  assign o_contact = i_coil;
endmodule : rlb_relay_coils

// file: tb/rlb_monitor.sv
// Checker on the relay bank's host and coil ports
`timescale 1ns/1ns
module rlb_monitor
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire rlb_pkg::rlb_req_s i_req,
  input wire rlb_pkg::rlb_rsp_s o_rsp,
  input wire logic [rlb_pkg::RELAY_COUNT-1:0] o_relay_close
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  wire logic rd;
  wire logic wr;
  assign rd = i_req.read && !i_req.write;
  assign wr = i_req.write;
  chk_read_inverts: assert property (rd |=> o_rsp.valid &&
    o_rsp.data == ~o_relay_close[rlb_pkg::PORT_WIDTH*$past(i_req.addr)
      +:rlb_pkg::PORT_WIDTH])
    else $error("bad read");
  chk_valid_pulse: assert property (!rd |=> !o_rsp.valid)
    else $error("bad valid");
  chk_idle_zero: assert property (!rd |=>
    o_rsp.data == rlb_pkg::READ_IDLE)
    else $error("read data not zero when idle");
  chk_write_lands: assert property (wr |-> ##2
    o_relay_close[rlb_pkg::PORT_WIDTH*$past(i_req.addr, 2)
      +:rlb_pkg::PORT_WIDTH] == $past(i_req.data, 2))
    else $error("written value not on coils");
  chk_coils_hold: assert property (!wr |=> ##1
    $stable(o_relay_close))
    else $error("coils moved without a write");
  chk_reset_open: assert property (disable iff (1'b0)
    i_reset |=> o_relay_close == '0 && !o_rsp.valid &&
      o_rsp.data == rlb_pkg::READ_IDLE)
    else $error("reset did not open the relays");
  cov_back_reads: cover property (rd ##1 rd);
  cov_write_read: cover property (wr ##1 rd);
  cov_refused_read: cover property (i_req.write && i_req.read);
endmodule : rlb_monitor
bind rlb_relay_bank rlb_monitor rlb_monitor_inst (.i_clock(i_clock),
  .i_reset(i_reset), .i_req(i_req), .o_rsp(o_rsp),
  .o_relay_close(o_relay_close));

// file: tb/tb_rlb_relay_bank.sv
// Bench
`timescale 1ns/1ns
module tb_rlb_relay_bank;
  logic i_clock = 1'b0, i_reset = 1'b1;
  rlb_pkg::rlb_req_s rq = '0;
  rlb_pkg::rlb_rsp_s rs;
  logic [31:0] q, k;
  logic [3:0][7:0] m = '0;
  logic [15:0] v = 16'h17;
  int error_cnt = 0, check_count = 0;
  rlb_relay_bank rlb_relay_bank_inst (.i_clock, .i_reset, .i_req(rq),
    .o_rsp(rs), .o_relay_close(q));
  rlb_relay_coils rlb_relay_coils_inst (.i_coil(q), .o_contact(k));
  always #50 i_clock = ~i_clock;
  function logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lf
  function logic [8:0] exp_rsp(input logic [7:0] d);
    return {1'b1, ~d};
  endfunction : exp_rsp
  task chk(input logic [31:0] s, e);
    check_count++;
    error_cnt += int'(s !== e);
    if (s !== e) $display("MISMATCH %0t %h %h", $time, s, e);
  endtask : chk
  task give_verdict(input int e);
    error_cnt += e;
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial #20000 give_verdict(1);
  initial
  begin
    repeat (5) @(negedge i_clock);
    i_reset = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      v = lf(v);
      rq = '{1'b0, 1'b1, v[11:10], 8'h00};
      @(negedge i_clock);
      chk(32'(rs), 32'(exp_rsp(m[v[11:10]])));
      chk(k, m);
      rq = '{1'b1, i[0], v[1:0], i < 2 ? 8'hFF : v[9:2]};
      m[v[1:0]] = rq.data;
      @(negedge i_clock);
    end
    rq = '{1'b1, 1'b1, 2'h2, 8'h3C};
    m[2] = 8'h3C;
    @(negedge i_clock);
    chk(32'(rs), 32'h0);
    rq = '{1'b0, 1'b1, 2'h2, 8'h00};
    @(negedge i_clock);
    chk(32'(rs), 32'(exp_rsp(m[2])));
    chk(k, m);
    rq = '0;
    i_reset = 1'b1;
    m = '0;
    repeat (2) @(negedge i_clock);
    i_reset = 1'b0;
    chk(32'(rs), 32'h0);
    chk(k, m);
    v = lf(v);
    rq = '{1'b0, 1'b1, v[1:0], 8'h00};
    @(negedge i_clock);
    chk(32'(rs), 32'(exp_rsp(m[v[1:0]])));
    rq = '0;
    @(negedge i_clock);
    give_verdict(0);
  end
endmodule : tb_rlb_relay_bank
